// >>> rtl/psag_core.sv
// Effective-address and program-space address generator of the core
`timescale 1ns/1ps
// ============================================================================
module psag_core (
  // Clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        nrst_i,
  // Instruction and flow fields from the decoder
  input  wire psag_pkg::psag_instr_s       instr_i,
  input  wire psag_pkg::psag_flow_s        flow_i,
  // Page registers and window enable
  input  wire logic                        page_we_i,
  input  wire logic                        page_sel_i,
  input  wire logic [psag_pkg::PAGE_W-1:0] page_wdata_i,
  input  wire logic                        window_en_i,
  // Program memory read data
  input  wire logic [psag_pkg::PW-1:0]     prog_rdata_i,
  // Generated addresses and data
  output psag_pkg::psag_out_s              out_o,
  output logic      [psag_pkg::PW-1:0]     pc_o,
  output logic      [psag_pkg::PW-1:0]     branch_target_o,
  output logic      [psag_pkg::HOLD_W-1:0] hold_count_o,
  output logic      [psag_pkg::DW-1:0]     pointer_dbg_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [psag_pkg::NUM_WREGS-1:0][psag_pkg::DW-1:0] default_working_reg;
    logic [psag_pkg::PAGE_W-1:0]                    table_page_reg;
    logic [psag_pkg::PAGE_W-1:0]                    visibility_page_reg;
    logic [psag_pkg::PW-1:0]                        pc;
    logic [psag_pkg::PW-1:0]                        branch_target;
    logic [psag_pkg::HOLD_W-1:0]                    hold_count;
    psag_pkg::psag_out_s                            out;
    logic                                           tbl_rd_lo;
    logic                                           tbl_rd_hi;
    logic                                           byte_mode;
    logic                                           byte_sel;
  } psag_state_s;

  psag_state_s state_q;
  psag_state_s state_d;

  // Working variables of the combinational process
  logic [psag_pkg::DW-1:0] ptr_src;
  logic [psag_pkg::DW-1:0] ptr_dst;
  logic [psag_pkg::DW-1:0] base_val;
  logic [psag_pkg::DW-1:0] lit_ext;
  logic [psag_pkg::DW-1:0] step;
  logic [psag_pkg::DW-1:0] src_ea;
  logic [psag_pkg::DW-1:0] dst_ea;
  logic [psag_pkg::DW-1:0] src_upd;
  logic [psag_pkg::DW-1:0] dst_upd;
  logic                    src_wb;
  logic                    dst_wb;
  logic [psag_pkg::DW-1:0] tdata;

  // EA for one addressing mode; returns the written-back pointer through upd
  function automatic logic [psag_pkg::DW-1:0] calc_ea(
    input  psag_pkg::psag_am_e      am,
    input  logic [psag_pkg::DW-1:0] ptr,
    input  logic [psag_pkg::DW-1:0] base,
    input  logic [psag_pkg::DW-1:0] lit,
    input  logic [psag_pkg::DW-1:0] pre,
    input  logic [psag_pkg::DW-1:0] stp,
    output logic [psag_pkg::DW-1:0] upd,
    output logic                    wb
  );
    logic [psag_pkg::DW-1:0] ea;
    ea  = ptr;
    upd = ptr;
    wb  = 1'b0;
    case (am)
      psag_pkg::PSAG_AM_IND: begin
        ea = ptr;
      end
      psag_pkg::PSAG_AM_POSTINC: begin
        ea  = ptr;
        upd = psag_pkg::DW'(ptr + stp);
        wb  = 1'b1;
      end
      psag_pkg::PSAG_AM_POSTDEC: begin
        ea  = ptr;
        upd = psag_pkg::DW'(ptr - stp);
        wb  = 1'b1;
      end
      psag_pkg::PSAG_AM_PRE: begin
        upd = psag_pkg::DW'(ptr + pre);
        ea  = upd;
        wb  = 1'b1;
      end
      psag_pkg::PSAG_AM_INDEXED: begin
        ea = psag_pkg::DW'(ptr + base);
      end
      psag_pkg::PSAG_AM_LITOFF: begin
        ea = psag_pkg::DW'(ptr + lit);
      end
      default: begin
        ea = ptr;
      end
    endcase
    return ea;
  endfunction : calc_ea

  // ==========================================================================
  // Next-state logic
  always_comb begin
    state_d  = state_q;
    ptr_src  = state_q.default_working_reg[instr_i.src_reg];
    ptr_dst  = state_q.default_working_reg[instr_i.dst_reg];
    base_val = state_q.default_working_reg[instr_i.base_reg];
    src_ea   = psag_pkg::ZERO_DW;
    dst_ea   = psag_pkg::ZERO_DW;
    src_upd  = ptr_src;
    dst_upd  = ptr_dst;
    src_wb   = 1'b0;
    dst_wb   = 1'b0;
    tdata    = psag_pkg::ZERO_DW;
    // Byte ops step the pointer by one, word ops by two
    step     = instr_i.byte_mode ? psag_pkg::STEP_BY : psag_pkg::STEP_WD;
    // Ten-bit literal for the wide forms, five-bit otherwise
    if (instr_i.opnd2 == psag_pkg::PSAG_SRC_LIT10) begin
      lit_ext = {{(psag_pkg::DW-psag_pkg::LIT10_W){1'b0}}, instr_i.literal};
    end else begin
      lit_ext = {{(psag_pkg::DW-psag_pkg::LIT5_W){1'b0}}, instr_i.literal[psag_pkg::LIT5_W-1:0]};
    end

    // Program counter steps one word, i.e. two address units, on each cycle with fetch_adv set
    if (flow_i.fetch_adv) begin
      state_d.pc = psag_pkg::PW'(state_q.pc + psag_pkg::PC_STEP);
    end
    // Branch target from signed literal; hold count from unsigned field
    if (flow_i.branch_op) begin
      state_d.branch_target = psag_pkg::PW'(state_q.pc
        + {{(psag_pkg::PW-psag_pkg::BRA_W){flow_i.branch_lit[psag_pkg::BRA_W-1]}}, flow_i.branch_lit});
    end
    if (flow_i.interrupt_hold_op) begin
      state_d.hold_count = flow_i.hold_lit;
    end

    // Page register writes
    if (page_we_i && !page_sel_i) begin
      state_d.table_page_reg = page_wdata_i;
    end
    if (page_we_i && page_sel_i) begin
      state_d.visibility_page_reg = page_wdata_i;
    end

    // Result path defaults
    state_d.out.valid         = 1'b0;
    state_d.out.prog_rd       = 1'b0;
    state_d.out.prog_wr       = 1'b0;
    state_d.out.prog_wr_hi    = 1'b0;
    state_d.out.window_hit    = 1'b0;
    state_d.out.pair_write    = 1'b0;
    state_d.out.result_to_reg = 1'b0;
    state_d.tbl_rd_lo         = 1'b0;
    state_d.tbl_rd_hi         = 1'b0;

    if (instr_i.valid) begin
      state_d.out.valid = 1'b1;
      state_d.byte_mode = instr_i.byte_mode;
      case (instr_i.op)
        psag_pkg::PSAG_OP_FILE: begin
          // Direct address limited to near space; move may use a full EA
          if (instr_i.is_move && instr_i.src_am != psag_pkg::PSAG_AM_FILE) begin
            src_ea = calc_ea(instr_i.src_am, ptr_src, base_val, lit_ext, instr_i.pre_offset, step,
                             src_upd, src_wb);
          end else begin
            src_ea = {{(psag_pkg::DW-psag_pkg::NEAR_W){1'b0}}, instr_i.file_addr};
          end
          dst_ea = src_ea;
          state_d.out.operand1   = state_q.default_working_reg[psag_pkg::WREG0];
          state_d.out.result_reg = instr_i.is_multiply ? instr_i.dst_reg : psag_pkg::WREG0;
          state_d.out.result_to_reg = instr_i.to_default_working_reg || instr_i.is_multiply;
          state_d.out.pair_write    = instr_i.is_multiply;
        end
        psag_pkg::PSAG_OP_MOVE: begin
          // Source and destination modes are independent, base field shared
          src_ea = calc_ea(instr_i.src_am, ptr_src, base_val, lit_ext, instr_i.pre_offset, step,
                           src_upd, src_wb);
          dst_ea = calc_ea(instr_i.dst_am, ptr_dst, base_val, lit_ext, instr_i.pre_offset, step,
                           dst_upd, dst_wb);
          state_d.out.operand1      = (instr_i.src_am == psag_pkg::PSAG_AM_DIRECT) ? ptr_src : src_ea;
          state_d.out.result_reg    = instr_i.dst_reg;
          state_d.out.result_to_reg = (instr_i.dst_am == psag_pkg::PSAG_AM_DIRECT);
        end
        psag_pkg::PSAG_OP_ALU3: begin
          state_d.out.operand1 = base_val;
          case (instr_i.opnd2)
            psag_pkg::PSAG_SRC_DEFAULT_WORKING_REG: state_d.out.operand2 = ptr_src;
            psag_pkg::PSAG_SRC_MEM: begin
              src_ea = calc_ea(instr_i.src_am, ptr_src, base_val, lit_ext, instr_i.pre_offset, step,
                               src_upd, src_wb);
              state_d.out.operand2 = src_ea;
            end
            default: state_d.out.operand2 = lit_ext;
          endcase
          dst_ea = calc_ea(instr_i.dst_am, ptr_dst, base_val, lit_ext, instr_i.pre_offset, step,
                           dst_upd, dst_wb);
          state_d.out.result_reg    = instr_i.dst_reg;
          state_d.out.result_to_reg = (instr_i.dst_am == psag_pkg::PSAG_AM_DIRECT);
        end
        psag_pkg::PSAG_OP_TBL_RD_LO, psag_pkg::PSAG_OP_TBL_RD_HI,
        psag_pkg::PSAG_OP_TBL_WR_LO, psag_pkg::PSAG_OP_TBL_WR_HI: begin
          src_ea = calc_ea(instr_i.src_am, ptr_src, base_val, lit_ext, instr_i.pre_offset, step,
                           src_upd, src_wb);
          // Full EA kept, no alignment forced for table operations
          state_d.out.prog_addr = {state_q.table_page_reg, src_ea};
          state_d.out.prog_cfg  = state_q.table_page_reg[psag_pkg::PAGE_MSB];
          state_d.byte_sel      = src_ea[0];
          state_d.out.prog_rd   = (instr_i.op == psag_pkg::PSAG_OP_TBL_RD_LO)
                               || (instr_i.op == psag_pkg::PSAG_OP_TBL_RD_HI);
          state_d.out.prog_wr   = (instr_i.op == psag_pkg::PSAG_OP_TBL_WR_LO)
                               || (instr_i.op == psag_pkg::PSAG_OP_TBL_WR_HI);
          state_d.out.prog_wr_hi = (instr_i.op == psag_pkg::PSAG_OP_TBL_WR_HI);
          state_d.tbl_rd_lo     = (instr_i.op == psag_pkg::PSAG_OP_TBL_RD_LO);
          state_d.tbl_rd_hi     = (instr_i.op == psag_pkg::PSAG_OP_TBL_RD_HI);
          state_d.out.operand1  = instr_i.wdata;
        end
        default: begin
          state_d.out.valid = 1'b0;
        end
      endcase

      // Data EA in the upper half maps through the visibility page (reads only)
      if (instr_i.op != psag_pkg::PSAG_OP_TBL_RD_LO && instr_i.op != psag_pkg::PSAG_OP_TBL_RD_HI
          && instr_i.op != psag_pkg::PSAG_OP_TBL_WR_LO && instr_i.op != psag_pkg::PSAG_OP_TBL_WR_HI
          && window_en_i && src_ea[psag_pkg::EA_MSB]) begin
        state_d.out.prog_addr  = {1'b0, state_q.visibility_page_reg,
                                  src_ea[psag_pkg::EA_MSB-1:1], 1'b0};
        state_d.out.prog_cfg   = 1'b0;
        state_d.out.prog_rd    = 1'b1;
        state_d.out.prog_wr    = 1'b0;
        state_d.out.window_hit = 1'b1;
        state_d.tbl_rd_lo      = 1'b1;
        state_d.byte_sel       = 1'b0;
      end

      state_d.out.src_ea = src_ea;
      state_d.out.dst_ea = dst_ea;
      // Destination writeback last so it wins when both name one register
      if (src_wb) begin
        state_d.default_working_reg[instr_i.src_reg] = src_upd;
      end
      if (dst_wb) begin
        state_d.default_working_reg[instr_i.dst_reg] = dst_upd;
      end
    end

    // Table read data returns one cycle after the program address
    if (state_q.tbl_rd_lo) begin
      if (state_q.byte_mode && !state_q.out.window_hit) begin
        tdata = {psag_pkg::ZERO_B, state_q.byte_sel ? prog_rdata_i[15:8] : prog_rdata_i[7:0]};
      end else begin
        tdata = prog_rdata_i[15:0];
      end
      state_d.out.table_data = tdata;
    end else if (state_q.tbl_rd_hi) begin
      if (state_q.byte_mode && state_q.byte_sel) begin
        tdata = psag_pkg::ZERO_DW;
      end else begin
        tdata = {psag_pkg::ZERO_B, prog_rdata_i[23:16]};
      end
      state_d.out.table_data = tdata;
    end
  end

  // ==========================================================================
  // State register, synchronous active-low reset
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state_q <= '0;
      state_q.pc <= psag_pkg::PC_RST;
      state_q.table_page_reg <= psag_pkg::PAGE_RST;
      state_q.visibility_page_reg <= psag_pkg::PAGE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the state register, except pointer_dbg_o, which instr_i.src_reg selects
  assign out_o           = state_q.out;
  assign pc_o            = state_q.pc;
  assign branch_target_o = state_q.branch_target;
  assign hold_count_o    = state_q.hold_count;
  assign pointer_dbg_o   = state_q.default_working_reg[instr_i.src_reg];

endmodule : psag_core

// >>> rtl/psag_pkg.sv
// Package of constants and carrier types for the program-space address generator
package psag_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned DW       = 16;
  localparam int unsigned PW       = 24;
  localparam int unsigned NEAR_W   = 13;
  localparam int unsigned PAGE_W   = 8;
  localparam int unsigned REG_W    = 4;
  localparam int unsigned LIT5_W   = 5;
  localparam int unsigned LIT10_W  = 10;
  localparam int unsigned BRA_W    = 16;
  localparam int unsigned HOLD_W   = 14;

  // ==========================================================================
  // Field positions and fixed values
  localparam int unsigned EA_MSB       = 15;
  localparam int unsigned PAGE_MSB     = 7;
  localparam int unsigned NUM_WREGS    = 16;
  localparam logic [REG_W-1:0] WREG0   = 4'h0;
  localparam logic [DW-1:0]    STEP_WD = 16'h0002;
  localparam logic [DW-1:0]    STEP_BY = 16'h0001;
  localparam logic [DW-1:0]    ZERO_DW = 16'h0000;
  localparam logic [PW-1:0]    ZERO_PW = 24'h000000;
  localparam logic [7:0]       ZERO_B  = 8'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;
  localparam logic [PW-1:0]    PC_RST  = 24'h000000;
  localparam logic [PW-1:0]    PC_STEP = 24'h000002;

  // ==========================================================================
  // Operand / addressing modes
  typedef enum logic [2:0] {
    PSAG_AM_DIRECT,
    PSAG_AM_IND,
    PSAG_AM_POSTINC,
    PSAG_AM_POSTDEC,
    PSAG_AM_PRE,
    PSAG_AM_INDEXED,
    PSAG_AM_LITOFF,
    PSAG_AM_FILE
  } psag_am_e;

  // Operation class
  typedef enum logic [2:0] {
    PSAG_OP_NONE,
    PSAG_OP_FILE,
    PSAG_OP_MOVE,
    PSAG_OP_ALU3,
    PSAG_OP_TBL_RD_LO,
    PSAG_OP_TBL_RD_HI,
    PSAG_OP_TBL_WR_LO,
    PSAG_OP_TBL_WR_HI
  } psag_op_e;

  // Second operand source for three-operand instructions
  typedef enum logic [1:0] {
    PSAG_SRC_DEFAULT_WORKING_REG,
    PSAG_SRC_MEM,
    PSAG_SRC_LIT5,
    PSAG_SRC_LIT10
  } psag_src_e;

  // Decoded instruction fields from the core
  typedef struct packed {
    logic                 valid;
    psag_op_e             op;
    psag_am_e             src_am;
    psag_am_e             dst_am;
    logic [REG_W-1:0]     src_reg;
    logic [REG_W-1:0]     dst_reg;
    logic [REG_W-1:0]     base_reg;
    psag_src_e            opnd2;
    logic [LIT10_W-1:0]   literal;
    logic [NEAR_W-1:0]    file_addr;
    logic [DW-1:0]        pre_offset;
    logic                 byte_mode;
    logic                 to_default_working_reg;
    logic                 is_multiply;
    logic                 is_move;
    logic [DW-1:0]        wdata;
  } psag_instr_s;

  // Branch / interrupt hold literals
  typedef struct packed {
    logic                 branch_op;
    logic [BRA_W-1:0]     branch_lit;
    logic                 interrupt_hold_op;
    logic [HOLD_W-1:0]    hold_lit;
    logic                 fetch_adv;
  } psag_flow_s;

  // Generated addresses and read data
  typedef struct packed {
    logic                 valid;
    logic [DW-1:0]        src_ea;
    logic [DW-1:0]        dst_ea;
    logic [DW-1:0]        operand1;
    logic [DW-1:0]        operand2;
    logic [REG_W-1:0]     result_reg;
    logic                 result_to_reg;
    logic                 pair_write;
    logic [PW-1:0]        prog_addr;
    logic                 prog_rd;
    logic                 prog_wr;
    logic                 prog_wr_hi;
    logic                 prog_cfg;
    logic                 window_hit;
    logic [DW-1:0]        table_data;
  } psag_out_s;

endpackage : psag_pkg

// >>> sim/psag_props.sv
// Port-level checker of the address generator
`timescale 1ns/1ps
module psag_props (
  // Clock and reset
  input wire logic                        clock_i,
  input wire logic                        nrst_i,
  // Inputs of the generator
  input wire psag_pkg::psag_instr_s       instr_i,
  input wire psag_pkg::psag_flow_s        flow_i,
  input wire logic                        window_en_i,
  // Outputs of the generator
  input wire psag_pkg::psag_out_s         out_o,
  input wire logic [psag_pkg::PW-1:0]     pc_o,
  input wire logic [psag_pkg::PW-1:0]     branch_target_o,
  input wire logic [psag_pkg::HOLD_W-1:0] hold_count_o,
  input wire logic [psag_pkg::DW-1:0]     pointer_dbg_o
);
  // ==========================================================================
  // Common clocking
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // High table reads, whole word and odd byte
  sequence s_hi_word;
    instr_i.valid && instr_i.op == psag_pkg::PSAG_OP_TBL_RD_HI && !instr_i.byte_mode;
  endsequence
  sequence s_hi_odd;
    instr_i.valid && instr_i.op == psag_pkg::PSAG_OP_TBL_RD_HI && instr_i.byte_mode &&
      instr_i.src_am == psag_pkg::PSAG_AM_IND && pointer_dbg_o[0];
  endsequence

  a_hi_word_zero: assert property (s_hi_word |-> ##2 out_o.table_data[15:8] == 8'h00)
    else $error("high word read upper byte not zero");
  a_hi_phantom: assert property (s_hi_odd |-> ##2 out_o.table_data == 16'h0000)
    else $error("phantom byte read not zero");
  a_valid_follows: assert property (nrst_i |=> out_o.valid ==
    $past(instr_i.valid && instr_i.op != psag_pkg::PSAG_OP_NONE))
    else $error("output valid not one cycle after request");
  a_indirect_ea: assert property (instr_i.valid && instr_i.op == psag_pkg::PSAG_OP_MOVE &&
    instr_i.src_am == psag_pkg::PSAG_AM_IND |=> out_o.src_ea == $past(pointer_dbg_o))
    else $error("indirect address differs from pointer");
  a_table_concat: assert property (out_o.prog_rd && !out_o.window_hit |->
    out_o.prog_addr[15:0] == out_o.src_ea && out_o.prog_cfg == out_o.prog_addr[23])
    else $error("table address not page over address");
  a_window_shape: assert property (out_o.window_hit |-> !out_o.prog_wr &&
    out_o.prog_addr[0] == 1'b0 && out_o.prog_addr[23] == 1'b0 && out_o.prog_addr[14:1] == out_o.src_ea[14:1]
    && out_o.src_ea[15] && $past(window_en_i))
    else $error("window address malformed");
  a_pc_step: assert property ($past(nrst_i) && $past(flow_i.fetch_adv) |->
    pc_o == $past(pc_o) + psag_pkg::PC_STEP)
    else $error("program counter step wrong");
  a_branch_sum: assert property ($past(nrst_i) && $past(flow_i.branch_op) |->
    branch_target_o == $past(pc_o) + 24'($signed($past(flow_i.branch_lit))))
    else $error("branch target wrong");
  a_hold_literal: assert property ($past(nrst_i) && $past(flow_i.interrupt_hold_op) |->
    hold_count_o == $past(flow_i.hold_lit))
    else $error("hold literal wrong");
  a_file_default_working_reg: assert property (instr_i.valid && instr_i.op == psag_pkg::PSAG_OP_FILE &&
    instr_i.to_default_working_reg && !instr_i.is_multiply |=> out_o.result_reg == psag_pkg::WREG0 && out_o.result_to_reg)
    else $error("file result not to default register");
endmodule : psag_props

bind psag_core psag_props u_psag_props (.clock_i, .nrst_i, .instr_i, .flow_i, .window_en_i, .out_o, .pc_o,
  .branch_target_o, .hold_count_o, .pointer_dbg_o);

// >>> sim/psag_prog_mem.sv
// Behavioural program memory answering table and window reads
`timescale 1ns/1ps
module psag_prog_mem (
  // Clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    nrst_i,
  // Read request
  input  wire logic [psag_pkg::PW-1:0] addr_i,
  input  wire logic                    rd_i,
  // Program word
  output logic      [psag_pkg::PW-1:0] rdata_o
);
  logic [psag_pkg::PW-1:0] last_q;

  // Each byte lane differs per address
  function automatic logic [23:0] word_at(input logic [23:0] a);
    return {a[7:0] ^ 8'h5A, a[15:0] ^ 16'hC3A5};
  endfunction : word_at

  // Idle bus shows inverse of last word
  always_comb rdata_o = rd_i ? word_at(addr_i) : ~last_q;

  // Remember the last word handed out
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      last_q <= 24'h000000;
    end else if (rd_i) begin
      last_q <= rdata_o;
    end
  end
endmodule : psag_prog_mem

// >>> sim/psag_core_tb_top.sv
// Self-checking bench of the address generator
`timescale 1ns/1ps
module psag_core_tb_top;
  // ==========================================================================
  // Signals
  logic                        clock_i;
  logic                        nrst_i;
  psag_pkg::psag_instr_s       instr_i;
  psag_pkg::psag_flow_s        flow_i;
  logic                        page_we_i;
  logic                        page_sel_i;
  logic [psag_pkg::PAGE_W-1:0] page_wdata_i;
  logic                        window_en_i;
  logic [psag_pkg::PW-1:0]     prog_rdata_i;
  psag_pkg::psag_out_s         out_o;
  logic [psag_pkg::PW-1:0]     pc_o;
  logic [psag_pkg::PW-1:0]     branch_target_o;
  logic [psag_pkg::HOLD_W-1:0] hold_count_o;
  logic [psag_pkg::DW-1:0]     pointer_dbg_o;
  int                          num_errors = 0;
  int                          n_compared = 0;
  int                          cycles = 0;

  psag_core u_psag_core (.clock_i, .nrst_i, .instr_i, .flow_i, .page_we_i, .page_sel_i, .page_wdata_i,
    .window_en_i, .prog_rdata_i, .out_o, .pc_o, .branch_target_o, .hold_count_o, .pointer_dbg_o);
  // Window reads fetch as well
  psag_prog_mem u_psag_prog_mem (.clock_i, .nrst_i, .addr_i(out_o.prog_addr),
    .rd_i(out_o.prog_rd | out_o.window_hit), .rdata_o(prog_rdata_i));

  // 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Hang guard, well above run length
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      summarize();
    end
  end

  // ==========================================================================
  // Helpers
  function automatic logic [23:0] pw(input logic [23:0] a);
    return {a[7:0] ^ 8'h5A, a[15:0] ^ 16'hC3A5};
  endfunction : pw

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  function automatic psag_pkg::psag_instr_s mk(input psag_pkg::psag_op_e op, input psag_pkg::psag_am_e sa,
      input logic [3:0] sr, input psag_pkg::psag_am_e da, input logic [3:0] dr);
    psag_pkg::psag_instr_s i;
    i = '0;
    i.valid = 1'b1;
    i.op = op;
    i.src_am = sa;
    i.src_reg = sr;
    i.dst_am = da;
    i.dst_reg = dr;
    return i;
  endfunction : mk

  // One edge, then valid low
  task automatic go(input psag_pkg::psag_instr_s i);
    instr_i = i;
    @(negedge clock_i);
    instr_i.valid = 1'b0;
  endtask : go

  // Pre-modify from zero loads the value
  task automatic setp(input logic [3:0] r, input logic [15:0] v);
    psag_pkg::psag_instr_s i;
    i = mk(psag_pkg::PSAG_OP_MOVE, psag_pkg::PSAG_AM_PRE, r, psag_pkg::PSAG_AM_DIRECT, 4'h0);
    i.pre_offset = v;
    go(i);
  endtask : setp

  task automatic page(input logic sel, input logic [7:0] v);
    page_we_i = 1'b1;
    page_sel_i = sel;
    page_wdata_i = v;
    @(negedge clock_i);
    page_we_i = 1'b0;
  endtask : page

  task automatic tbl(input psag_pkg::psag_op_e op, input logic bm, input logic [3:0] r, input logic [23:0] a,
      input logic [15:0] exp);
    psag_pkg::psag_instr_s i;
    i = mk(op, psag_pkg::PSAG_AM_IND, r, psag_pkg::PSAG_AM_DIRECT, 4'h0);
    i.byte_mode = bm;
    go(i);
    check("tbl addr", out_o.prog_addr, a);
    check("tbl cfg", out_o.prog_cfg, a[23]);
    check("tbl rd", out_o.prog_rd, 1'b1);
    check("tbl win", out_o.window_hit, 1'b0);
    @(negedge clock_i);
    check("tbl data", out_o.table_data, exp);
  endtask : tbl

  // ==========================================================================
  // Scenarios
  task automatic t_modify();
    psag_pkg::psag_instr_s i;
    i = mk(psag_pkg::PSAG_OP_MOVE, psag_pkg::PSAG_AM_PRE, 4'h1, psag_pkg::PSAG_AM_DIRECT, 4'h0);
    i.pre_offset = 16'hFFF0;
    go(i);
    check("pre ea", out_o.src_ea, 16'hFFF0);
    check("pre ptr", pointer_dbg_o, 16'hFFF0);
    check("full space", out_o.window_hit, 1'b0);
    i.src_am = psag_pkg::PSAG_AM_POSTINC;
    go(i);
    check("inc ea", out_o.src_ea, 16'hFFF0);
    check("inc ptr", pointer_dbg_o, 16'hFFF2);
    i.src_am = psag_pkg::PSAG_AM_POSTDEC;
    i.byte_mode = 1'b1;
    go(i);
    check("dec ea", out_o.src_ea, 16'hFFF2);
    check("dec ptr", pointer_dbg_o, 16'hFFF1);
    i.src_am = psag_pkg::PSAG_AM_IND;
    go(i);
    check("ind ea", out_o.src_ea, 16'hFFF1);
    check("ind ptr", pointer_dbg_o, 16'hFFF1);
  endtask : t_modify

  task automatic t_operands();
    psag_pkg::psag_instr_s i;
    setp(4'h2, 16'h1000);
    setp(4'h3, 16'h0030);
    i = mk(psag_pkg::PSAG_OP_MOVE, psag_pkg::PSAG_AM_INDEXED, 4'h2, psag_pkg::PSAG_AM_LITOFF, 4'h2);
    i.base_reg = 4'h3;
    i.opnd2 = psag_pkg::PSAG_SRC_LIT10;
    i.literal = 10'h3FF;
    go(i);
    check("indexed", out_o.src_ea, 16'h1030);
    check("lit off", out_o.dst_ea, 16'h13FF);
    i = mk(psag_pkg::PSAG_OP_ALU3, psag_pkg::PSAG_AM_DIRECT, 4'h2, psag_pkg::PSAG_AM_DIRECT, 4'h5);
    i.base_reg = 4'h3;
    i.opnd2 = psag_pkg::PSAG_SRC_LIT5;
    i.literal = 10'h3F5;
    go(i);
    check("op1", out_o.operand1, 16'h0030);
    check("lit5", out_o.operand2, 16'h0015);
    i.opnd2 = psag_pkg::PSAG_SRC_LIT10;
    go(i);
    check("lit10", out_o.operand2, 16'h03F5);
    i.opnd2 = psag_pkg::PSAG_SRC_DEFAULT_WORKING_REG;
    go(i);
    check("reg op2", out_o.operand2, 16'h1000);
    i = mk(psag_pkg::PSAG_OP_FILE, psag_pkg::PSAG_AM_FILE, 4'h0, psag_pkg::PSAG_AM_FILE, 4'h0);
    i.file_addr = 13'h1FFF;
    i.to_default_working_reg = 1'b1;
    go(i);
    check("file ea", out_o.src_ea, 16'h1FFF);
    check("file reg", out_o.result_reg, psag_pkg::WREG0);
    check("file to reg", out_o.result_to_reg, 1'b1);
  endtask : t_operands

  task automatic t_table();
    psag_pkg::psag_instr_s i;
    logic [23:0] w;
    setp(4'h4, 16'h2345);
    setp(4'h5, 16'hC100);
    page(1'b0, 8'h85);
    window_en_i = 1'b1;
    w = pw(24'h852345);
    tbl(psag_pkg::PSAG_OP_TBL_RD_LO, 1'b0, 4'h4, 24'h852345, w[15:0]);
    tbl(psag_pkg::PSAG_OP_TBL_RD_LO, 1'b1, 4'h4, 24'h852345, {8'h00, w[15:8]});
    tbl(psag_pkg::PSAG_OP_TBL_RD_HI, 1'b0, 4'h4, 24'h852345, {8'h00, w[23:16]});
    tbl(psag_pkg::PSAG_OP_TBL_RD_HI, 1'b1, 4'h4, 24'h852345, 16'h0000);
    page(1'b0, 8'h05);
    w = pw(24'h05C100);
    tbl(psag_pkg::PSAG_OP_TBL_RD_LO, 1'b1, 4'h5, 24'h05C100, {8'h00, w[7:0]});
    tbl(psag_pkg::PSAG_OP_TBL_RD_HI, 1'b1, 4'h5, 24'h05C100, {8'h00, w[23:16]});
    i = mk(psag_pkg::PSAG_OP_TBL_WR_HI, psag_pkg::PSAG_AM_IND, 4'h4, psag_pkg::PSAG_AM_DIRECT, 4'h0);
    go(i);
    check("wr", out_o.prog_wr, 1'b1);
    check("wr hi", out_o.prog_wr_hi, 1'b1);
    check("wr addr", out_o.prog_addr, 24'h052345);
  endtask : t_table

  task automatic t_window();
    psag_pkg::psag_instr_s i;
    logic [23:0] w;
    setp(4'h7, 16'h9235);
    page(1'b1, 8'hA7);
    i = mk(psag_pkg::PSAG_OP_MOVE, psag_pkg::PSAG_AM_IND, 4'h7, psag_pkg::PSAG_AM_DIRECT, 4'h0);
    go(i);
    check("win hit", out_o.window_hit, 1'b1);
    check("win addr", out_o.prog_addr, 24'h539234);
    check("win no wr", out_o.prog_wr, 1'b0);
    @(negedge clock_i);
    w = pw(24'h539234);
    check("win data", out_o.table_data, w[15:0]);
    go(mk(psag_pkg::PSAG_OP_MOVE, psag_pkg::PSAG_AM_DIRECT, 4'h0, psag_pkg::PSAG_AM_IND, 4'h7));
    check("win write", out_o.prog_wr, 1'b0);
    window_en_i = 1'b0;
    go(i);
    check("win off", out_o.window_hit, 1'b0);
    check("far ea", out_o.src_ea, 16'h9235);
  endtask : t_window

  task automatic t_flow();
    flow_i.fetch_adv = 1'b1;
    repeat (3) @(negedge clock_i);
    flow_i.fetch_adv = 1'b0;
    check("pc", pc_o, 24'h000006);
    flow_i.branch_op = 1'b1;
    flow_i.branch_lit = 16'hFFF0;
    @(negedge clock_i);
    flow_i.branch_op = 1'b0;
    check("branch", branch_target_o, 24'hFFFFF6);
    flow_i.interrupt_hold_op = 1'b1;
    flow_i.hold_lit = 14'h3FFF;
    @(negedge clock_i);
    flow_i.interrupt_hold_op = 1'b0;
    check("hold", hold_count_o, 14'h3FFF);
  endtask : t_flow

  // ==========================================================================
  // Main sequence
  initial begin
    nrst_i = 1'b0;
    instr_i = '0;
    flow_i = '0;
    page_we_i = 1'b0;
    page_sel_i = 1'b0;
    page_wdata_i = 8'h00;
    window_en_i = 1'b0;
    repeat (10) @(negedge clock_i);
    nrst_i = 1'b1;
    @(negedge clock_i);
    check("pc reset", pc_o, 24'h000000);
    check("valid reset", out_o.valid, 1'b0);
    t_modify();
    t_operands();
    t_table();
    t_window();
    t_flow();
    summarize();
  end
endmodule : psag_core_tb_top
